// *** core/mode_select_pkg.sv ***
// Purpose: Shared constants and types for the mode-selection register block
// Assumes: 16-bit register port, 512-word connection memory of 12-bit words
// Notes:   Offsets are word indexes on the plain register port
package mode_select_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int CM_W   = 12;
  localparam int CM_D   = 512;

  // Register offsets
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] MODE_OFS   = 12'h001;
  localparam logic [11:0] FRAMES_OFS = 12'h002;

  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] MODE_RST = 16'h0000;

  // Control register fields
  localparam int CTRL_BPE_BIT = 0;

  // Mode register fields
  localparam int IN_CLK_BIT   = 11;
  localparam int IN_FP_BIT    = 10;
  localparam int CK2_BIT      = 9;
  localparam int FP2_BIT      = 8;
  localparam int CK1_BIT      = 7;
  localparam int FP1_BIT      = 6;
  localparam int CK0_BIT      = 5;
  localparam int FP0_BIT      = 4;
  localparam int PAT_HI       = 3;
  localparam int PAT_LO       = 1;
  localparam int START_BIT    = 0;
  localparam logic [15:0] MODE_RSVD_MASK = 16'hF000;

  // Pattern width inside a connection memory word
  localparam int PAT_W = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_type;

  typedef struct packed {
    logic clk;
    logic fp;
  } timing_pair_type;

  typedef enum logic [0:0] {
    PROG_IDLE,
    PROG_FILL
  } prog_state_type;

endpackage

// *** core/cm_memory.sv ***
// Purpose: Connection memory, one write port and one registered read port
// Assumes: Single clock, writes and reads may hit the same word
// Notes:   Read data appear one cycle after the address
`timescale 1ns/10ps
module cm_memory #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 512,
  parameter int AW    = 9
) (
  // Clock
  input  wire logic             clock,
  // Write port
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // Read port
  input  wire logic [AW-1:0]    rdAddr,
  output      logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule

// *** core/internal_mode_select_reg.sv ***
// Purpose: Mode-selection register with clock/frame polarity control and block load
// Assumes: Serial clock and frame inputs are slow against the 100 MHz clock
// Notes:   Outputs follow the synchronised inputs, three cycles behind the pins
//          Reserved mode bits are stored and read back as written
//          Frame count is read-only; connection memory words are not reset
//
// Functional notes
// - Input clock edge bit: 0 falling, 1 rising edge marks frame boundary.
// - Input frame polarity bit: 0 negative pulse, 1 positive pulse.
// - Output clock two: bit selects falling or rising edge at boundary.
// - Output frame two: bit selects negative or positive pulse.
// - Output clock one: bit selects falling or rising edge at boundary.
// - Output frame one: bit selects negative or positive pulse.
// - Output clock zero: bit selects falling or rising edge at boundary.
// - Output frame zero: bit selects negative or positive pulse.
// - Enable and start, set in either order, load pattern into connection memory bits 2-0.
// - The same block load clears connection memory bits 11-3.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module internal_mode_select_reg #(
  parameter int CM_DEPTH = mode_select_pkg::CM_D,
  parameter int CM_AW    = 9
) (
  // Clock and reset
  input  wire logic                                  clock,
  input  wire logic                                  reset_n,
  // Register port
  input  wire mode_select_pkg::reg_req_type          regReq,
  output      logic [mode_select_pkg::DATA_W-1:0]    regRdata,
  // Serial timing inputs
  input  wire logic                                  serial_clock_input,
  input  wire logic                                  frame_pulse_input,
  // Serial timing outputs
  output      logic                                  serial_clock_out_zero,
  output      logic                                  frame_pulse_out_zero,
  output      logic                                  serial_clock_out_one,
  output      logic                                  frame_pulse_out_one,
  output      logic                                  serial_clock_out_two,
  output      logic                                  frame_pulse_out_two,
  output      logic                                  frameBoundary,
  // Connection memory access for the switch
  input  wire logic [CM_AW-1:0]                      cmRdAddr,
  output      logic [mode_select_pkg::CM_W-1:0]      cmRdData,
  output      logic                                  blockBusy
);

  // Registers
  logic [15:0]                        ctrl_r;
  logic [15:0]                        mode_r;
  logic [15:0]                        mode_nxt;
  logic [15:0]                        frames_r;
  logic [15:0]                        regRdata_r;
  mode_select_pkg::prog_state_type    state_r;
  mode_select_pkg::prog_state_type    state_nxt;
  logic [CM_AW-1:0]                   fillAddr_r;
  logic [1:0]                         ckSync_r;
  logic [1:0]                         fpSync_r;
  logic                               ckPrev_r;
  mode_select_pkg::timing_pair_type   out0_r;
  mode_select_pkg::timing_pair_type   out1_r;
  mode_select_pkg::timing_pair_type   out2_r;
  logic                               boundary_r;
  logic                               busy_r;

  // Register hit on one offset
  function automatic logic hitReg(input logic [mode_select_pkg::ADDR_W-1:0] addr,
                                  input logic [mode_select_pkg::ADDR_W-1:0] ofs);
    hitReg = (addr == ofs);
  endfunction

  // Decode
  wire logic        wrCtrl   = regReq.wr && hitReg(regReq.addr, mode_select_pkg::CTRL_OFS);
  wire logic        wrMode   = regReq.wr && hitReg(regReq.addr, mode_select_pkg::MODE_OFS);
  wire logic        rdCtrl   = regReq.rd && hitReg(regReq.addr, mode_select_pkg::CTRL_OFS);
  wire logic        rdMode   = regReq.rd && hitReg(regReq.addr, mode_select_pkg::MODE_OFS);
  wire logic        rdFrames = regReq.rd && hitReg(regReq.addr, mode_select_pkg::FRAMES_OFS);
  wire logic        fillLast = (fillAddr_r == CM_AW'(CM_DEPTH - 1));
  wire logic        fillDone = (state_r == mode_select_pkg::PROG_FILL) && fillLast;
  wire logic        progEn   = ctrl_r[mode_select_pkg::CTRL_BPE_BIT];
  wire logic        startReq = mode_r[mode_select_pkg::START_BIT];
  wire logic [2:0]  pattern  = mode_r[mode_select_pkg::PAT_HI:mode_select_pkg::PAT_LO];

  // Synchronised pins
  wire logic ckIn = ckSync_r[1];
  wire logic fpIn = fpSync_r[1];

  // Returns the output clock level whose chosen edge lines up with the input boundary edge
  function automatic logic alignClock(input logic inClk, input logic inEdge, input logic outEdge);
    alignClock = inClk ^ (inEdge ^ outEdge);
  endfunction

  // Returns the pin level for an active-high pulse under the given polarity bit
  function automatic logic shapePulse(input logic active, input logic posPol);
    shapePulse = active ^ ~posPol;
  endfunction

  wire logic inEdge   = mode_r[mode_select_pkg::IN_CLK_BIT];
  wire logic edgeSeen = inEdge ? (ckIn && !ckPrev_r) : (!ckIn && ckPrev_r);
  wire logic fpActive = fpIn ^ ~mode_r[mode_select_pkg::IN_FP_BIT];
  wire logic boundary = edgeSeen && fpActive;

  wire logic ck0Nxt = alignClock(ckIn, inEdge, mode_r[mode_select_pkg::CK0_BIT]);
  wire logic ck1Nxt = alignClock(ckIn, inEdge, mode_r[mode_select_pkg::CK1_BIT]);
  wire logic ck2Nxt = alignClock(ckIn, inEdge, mode_r[mode_select_pkg::CK2_BIT]);
  wire logic fp0Nxt = shapePulse(fpActive, mode_r[mode_select_pkg::FP0_BIT]);
  wire logic fp1Nxt = shapePulse(fpActive, mode_r[mode_select_pkg::FP1_BIT]);
  wire logic fp2Nxt = shapePulse(fpActive, mode_r[mode_select_pkg::FP2_BIT]);

  // Reserved bits stored as written, software keeps them zero
  // Start bit self-clears at the end of the load; a new write wins
  always_comb begin
    mode_nxt = mode_r;
    if (fillDone) begin
      mode_nxt[mode_select_pkg::START_BIT] = 1'b0;
    end
    if (wrMode) begin
      mode_nxt = regReq.wdata;
    end
  end

  // Load starts once enable and start are both set, in either order
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      mode_select_pkg::PROG_IDLE: begin
        if (progEn && startReq) begin
          state_nxt = mode_select_pkg::PROG_FILL;
        end
      end
      mode_select_pkg::PROG_FILL: begin
        if (fillLast) begin
          state_nxt = mode_select_pkg::PROG_IDLE;
        end
      end
    endcase
  end

  // Pattern in low bits, upper bits zero
  wire logic                             cmWrEn   = (state_r == mode_select_pkg::PROG_FILL);
  wire logic [mode_select_pkg::CM_W-1:0] cmWrData = {(mode_select_pkg::CM_W - mode_select_pkg::PAT_W)'(0), pattern};

  // Read mux
  wire logic [15:0] rdValue = rdCtrl   ? ctrl_r :
                              rdMode   ? mode_r :
                              rdFrames ? frames_r : 16'h0000;

  // Control register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= mode_select_pkg::CTRL_RST;
    end else if (wrCtrl) begin
      ctrl_r <= regReq.wdata;
    end
  end

  // Mode register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= mode_select_pkg::MODE_RST;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= mode_select_pkg::PROG_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Read data stand one cycle only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      regRdata_r <= 16'h0000;
    end else begin
      regRdata_r <= regReq.rd ? rdValue : 16'h0000;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt == mode_select_pkg::PROG_FILL);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fillAddr_r <= '0;
    end else if (cmWrEn) begin
      fillAddr_r <= fillLast ? '0 : fillAddr_r + CM_AW'(1);
    end
  end

  // Clock pin synchroniser
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ckSync_r <= 2'b00;
    end else begin
      ckSync_r <= {ckSync_r[0], serial_clock_input};
    end
  end

  // Frame pin synchroniser
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fpSync_r <= 2'b00;
    end else begin
      fpSync_r <= {fpSync_r[0], frame_pulse_input};
    end
  end

  // Clock history for edge detection
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ckPrev_r <= 1'b0;
    end else begin
      ckPrev_r <= ckIn;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out0_r <= '0;
    end else begin
      out0_r <= '{clk: ck0Nxt, fp: fp0Nxt};
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out1_r <= '0;
    end else begin
      out1_r <= '{clk: ck1Nxt, fp: fp1Nxt};
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out2_r <= '0;
    end else begin
      out2_r <= '{clk: ck2Nxt, fp: fp2Nxt};
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      boundary_r <= 1'b0;
    end else begin
      boundary_r <= boundary;
    end
  end

  // Frame count
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      frames_r <= 16'h0000;
    end else if (boundary) begin
      frames_r <= frames_r + 16'h0001;
    end
  end

  cm_memory #(
    .WIDTH (mode_select_pkg::CM_W),
    .DEPTH (CM_DEPTH),
    .AW    (CM_AW)
  ) u_cm (
    .clock  (clock),
    .wrEn   (cmWrEn),
    .wrAddr (fillAddr_r),
    .wrData (cmWrData),
    .rdAddr (cmRdAddr),
    .rdData (cmRdData)
  );

  assign regRdata              = regRdata_r;
  assign serial_clock_out_zero = out0_r.clk;
  assign frame_pulse_out_zero  = out0_r.fp;
  assign serial_clock_out_one  = out1_r.clk;
  assign frame_pulse_out_one   = out1_r.fp;
  assign serial_clock_out_two  = out2_r.clk;
  assign frame_pulse_out_two   = out2_r.fp;
  assign frameBoundary         = boundary_r;
  assign blockBusy             = busy_r;

endmodule

// *** testbench/serial_timing_source.sv ***
// Purpose: Serial clock and frame pulse source
// Assumes: Eight system clocks per serial clock period
// Notes:   Frame pulse spans one serial period around the falling edge
`timescale 1ns/10ps
module serial_timing_source (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // Format
  input  wire logic fpPositive,
  // Pins
  output      logic serialClk,
  output      logic framePulse
);
  logic [6:0] phase_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= 7'h00;
    end else begin
      phase_r <= phase_r + 7'h01;
    end
  end
  assign serialClk = phase_r[2];
  assign framePulse = (phase_r >= 7'h7C || phase_r < 7'h04) ? fpPositive : !fpPositive;
endmodule

// *** testbench/mode_select_monitor.sv ***
// Purpose: Port checker for the mode block
// Assumes: Pins change on the system clock edge
// Notes:   Mode word shadowed from writes
`timescale 1ns/10ps
module mode_select_monitor #(
  parameter int CM_DEPTH = 512
) (
  // Clock and reset
  input wire logic                               clock,
  input wire logic                               reset_n,
  // Register port
  input wire mode_select_pkg::reg_req_type       regReq,
  input wire logic [mode_select_pkg::DATA_W-1:0] regRdata,
  // Timing
  input wire logic                               serial_clock_input,
  input wire logic                               frame_pulse_input,
  input wire logic                               serial_clock_out_zero,
  input wire logic                               frame_pulse_out_zero,
  input wire logic                               serial_clock_out_one,
  input wire logic                               frame_pulse_out_one,
  input wire logic                               serial_clock_out_two,
  input wire logic                               frame_pulse_out_two,
  input wire logic                               frameBoundary,
  input wire logic                               blockBusy
);
  logic [15:0] m;
  logic [3:0]  q;
  logic [5:0]  ck;
  logic [5:0]  fp;
  int          busyN;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      m <= 16'h0000;
      q <= 4'h0;
      ck <= 6'h00;
      fp <= 6'h00;
      busyN <= 0;
    end else begin
      ck <= {ck[4:0], serial_clock_input};
      fp <= {fp[4:0], frame_pulse_input};
      busyN <= blockBusy ? busyN + 1 : 0;
      if (regReq.wr && regReq.addr == mode_select_pkg::MODE_OFS) begin
        m <= regReq.wdata;
        q <= 4'h0;
      end else if (q != 4'hF) begin
        q <= q + 4'h1;
      end
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_ck0; q > 4'h4 |-> serial_clock_out_zero == (ck[2] ^ m[5] ^ m[11]); endproperty
  a_ck0: assert property (p_ck0) else $error("clock zero wrong");
  property p_ck1; q > 4'h4 |-> serial_clock_out_one == (ck[2] ^ m[7] ^ m[11]); endproperty
  a_ck1: assert property (p_ck1) else $error("clock one wrong");
  property p_ck2; q > 4'h4 |-> serial_clock_out_two == (ck[2] ^ m[9] ^ m[11]); endproperty
  a_ck2: assert property (p_ck2) else $error("clock two wrong");
  property p_fp0; q > 4'h4 |-> frame_pulse_out_zero == (fp[2] ^ m[10] ^ m[4]); endproperty
  a_fp0: assert property (p_fp0) else $error("frame zero wrong");
  property p_fp1; q > 4'h4 |-> frame_pulse_out_one == (fp[2] ^ m[10] ^ m[6]); endproperty
  a_fp1: assert property (p_fp1) else $error("frame one wrong");
  property p_fp2; q > 4'h4 |-> frame_pulse_out_two == (fp[2] ^ m[10] ^ m[8]); endproperty
  a_fp2: assert property (p_fp2) else $error("frame two wrong");
  property p_bnd; frameBoundary && q > 4'h5 |-> ck[2] == m[11] && ck[3] != m[11] && fp[2] == m[10]; endproperty
  a_bnd: assert property (p_bnd) else $error("boundary wrong");
  property p_rd; regReq.rd && regReq.addr == mode_select_pkg::MODE_OFS |=> regRdata[15:1] == $past(m[15:1]); endproperty
  a_rd: assert property (p_rd) else $error("mode readback wrong");
  property p_idle; !$past(regReq.rd) |-> regRdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_busy; $fell(blockBusy) |-> busyN == CM_DEPTH; endproperty
  a_busy: assert property (p_busy) else $error("load length wrong");
endmodule
bind internal_mode_select_reg mode_select_monitor #(.CM_DEPTH(CM_DEPTH)) mon_u (
  .clock(clock), .reset_n(reset_n), .regReq(regReq), .regRdata(regRdata),
  .serial_clock_input(serial_clock_input), .frame_pulse_input(frame_pulse_input),
  .serial_clock_out_zero(serial_clock_out_zero), .frame_pulse_out_zero(frame_pulse_out_zero),
  .serial_clock_out_one(serial_clock_out_one), .frame_pulse_out_one(frame_pulse_out_one),
  .serial_clock_out_two(serial_clock_out_two), .frame_pulse_out_two(frame_pulse_out_two),
  .frameBoundary(frameBoundary), .blockBusy(blockBusy));

// *** testbench/tb.sv ***
// Purpose: Directed bench for the mode block
// Assumes: Partner drives serial clock and frame pulse
// Notes:   Connection memory shortened to 16 words
`timescale 1ns/10ps
module tb;
  localparam int DEPTH = 16;
  logic                         clock = 1'b0;
  logic                         reset_n = 1'b0;
  mode_select_pkg::reg_req_type regReq = '0;
  logic [15:0]                  regRdata;
  logic                         sck, sfp, ck0, fp0, ck1, fp1, ck2, fp2, bound, busy;
  logic                         fpPos = 1'b0;
  logic [3:0]                   cmRdAddr = 4'h0;
  logic [11:0]                  cmRdData;
  logic [15:0]                  pats [4] = '{16'h0AAE, 16'h0550, 16'h0FF0, 16'h0000};
  int                           mismatches = 0;
  int                           n_compared = 0;
  int                           cycles = 0;
  int                           n;
  serial_timing_source src_u (.clock(clock), .reset_n(reset_n), .fpPositive(fpPos),
    .serialClk(sck), .framePulse(sfp));
  internal_mode_select_reg #(.CM_DEPTH(DEPTH), .CM_AW(4)) dut_u (.clock(clock), .reset_n(reset_n),
    .regReq(regReq), .regRdata(regRdata), .serial_clock_input(sck), .frame_pulse_input(sfp),
    .serial_clock_out_zero(ck0), .frame_pulse_out_zero(fp0), .serial_clock_out_one(ck1),
    .frame_pulse_out_one(fp1), .serial_clock_out_two(ck2), .frame_pulse_out_two(fp2),
    .frameBoundary(bound), .cmRdAddr(cmRdAddr), .cmRdData(cmRdData), .blockBusy(busy));
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clock);
    regReq.addr <= a;
    regReq.wdata <= d;
    regReq.wr <= 1'b1;
    @(posedge clock);
    regReq.wr <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clock);
    regReq.addr <= a;
    regReq.rd <= 1'b1;
    @(posedge clock);
    regReq.rd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  task waitFor(input logic lvl, input int lim);
    n = 0;
    while (busy === lvl && n < lim) begin
      @(posedge clock);
      #1 n++;
    end
  endtask
  task load(input logic [15:0] expMode, input logic [11:0] expWord);
    waitFor(1'b0, 8);
    waitFor(1'b1, 100);
    chk(16'(n), 16'(DEPTH));
    rd(mode_select_pkg::MODE_OFS, expMode);
    for (int a = 0; a < DEPTH; a++) begin
      @(posedge clock);
      cmRdAddr <= 4'(a);
      @(posedge clock);
      #1 chk({4'h0, cmRdData}, {4'h0, expWord});
    end
  endtask
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    rd(mode_select_pkg::FRAMES_OFS, 16'h0000);
    rd(mode_select_pkg::MODE_OFS, mode_select_pkg::MODE_RST);
    rd(mode_select_pkg::CTRL_OFS, mode_select_pkg::CTRL_RST);
    rd(12'h0F0, 16'h0000);
    foreach (pats[i]) begin
      fpPos <= pats[i][10];
      wr(mode_select_pkg::MODE_OFS, pats[i]);
      rd(mode_select_pkg::MODE_OFS, pats[i]);
      n = 0;
      repeat (300) @(posedge clock) n += (bound === 1'b1);
      chk(16'(n > 0), 16'h0001);
    end
    wr(mode_select_pkg::MODE_OFS, 16'h0007);
    repeat (8) @(posedge clock);
    #1 chk({15'h0, busy}, 16'h0000);
    wr(mode_select_pkg::CTRL_OFS, 16'h0001);
    load(16'h0006, 12'h003);
    wr(mode_select_pkg::MODE_OFS, 16'h000B);
    load(16'h000A, 12'h005);
    print_verdict();
  end
endmodule
